// ===== verilog/irq_ctrl_top.sv
/*
  Interrupt block top: APB slave with alarm flags, mask bank,
  raw status registers and one level interrupt output.
  Assumes an APB master on pclk and status inputs synchronous to pclk.
*/
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
// Overview of operation
// - Each of four alarm flags, bits 3..0, sets on its event's rising edge.
// - A flag clears only when software writes one; zero leaves it.
// - One mask bit per flag; mask bank mirrors flag registers bit for bit.
// - Mask zero lets a flag reach the interrupt; one blocks it.
// - Control interface error shows live in bit 12 of first raw status.
// - Bit 7 of first raw status reads zero while booting, one when done.
// - Bit 14 of second raw status flags too few core clock cycles.
// - Bit 13 of second raw status flags too few asynchronous clock cycles.
// - Bit 12 of second raw status flags too few main clock cycles.
// - Second loop: bit 9 reads locked, bit 6 reads reference lost.
// - First loop: bit 8 reads locked, bit 5 reads reference lost.
module irq_ctrl_top (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave port.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [irq_pkg::ADDR_W-1:0] paddr,
  input wire logic [irq_pkg::DATA_W-1:0] pwdata,
  output logic pready,
  output logic [irq_pkg::DATA_W-1:0] prdata,
  output logic pslverr,
  // Alarm channel events.
  input wire logic [irq_pkg::ALARM_CHANNELS-1:0] alarm_event,
  // Live conditions for the raw status registers.
  input wire logic host_port_error_state,
  input wire logic core_clock_shortfall_state,
  input wire logic async_clock_shortfall_state,
  input wire logic system_clock_shortfall_state,
  input wire logic loop_a_lock_state,
  input wire logic loop_b_lock_state,
  input wire logic loop_a_ref_loss_state,
  input wire logic loop_b_ref_loss_state,
  // Interrupt output.
  output logic irq_out
);
  import irq_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [IDX_W-1:0] word_idx;
  logic aligned;
  logic hit_flags;
  logic hit_mask;
  logic hit_raw1;
  logic hit_raw2;
  logic mapped;
  logic [MASK_SEL_W-1:0] mask_sel;
  logic setup_phase;
  logic wr_en;
  logic [DATA_W-1:0] rdata_d;
  logic [DATA_W-1:0] prdata_q;
  logic pslverr_q;
  logic [REG_W-1:0] mask_q [MASK_COUNT];
  logic [ALARM_CHANNELS-1:0] alarm_mask;
  logic [ALARM_CHANNELS-1:0] pending;
  logic irq_q;
  logic boot_done;
  logic [REG_W-1:0] raw_first_d;
  logic [REG_W-1:0] raw_second_d;
  logic [REG_W-1:0] raw_first_q;
  logic [REG_W-1:0] raw_second_q;

  flag_bus_if fb ();

  // ----------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------

  // Latched alarm flags.
  alarm_flag_bank u_flags (
    .pclk(pclk),
    .presetn(presetn),
    .fb(fb.bank)
  );

  // Boot sequence timer.
  boot_sequencer u_boot (
    .pclk(pclk),
    .presetn(presetn),
    .boot_done(boot_done)
  );

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------

  // Word index from the byte address; misaligned addresses are unmapped.
  assign word_idx = paddr[ADDR_W-1:2];
  assign aligned = (paddr[1:0] == 2'b00);

  // Select the addressed register.
  always_comb begin
    hit_flags = 1'b0;
    hit_mask = 1'b0;
    hit_raw1 = 1'b0;
    hit_raw2 = 1'b0;
    mask_sel = '0;
    if (!aligned) begin
      hit_flags = 1'b0;
    end else if (word_idx == IDX_ALARM_FLAGS) begin
      hit_flags = 1'b1;
    end else if (word_idx >= IDX_MASK_FIRST && word_idx <= IDX_MASK_LAST) begin
      hit_mask = 1'b1;
      mask_sel = MASK_SEL_W'(word_idx - IDX_MASK_FIRST);
    end else if (word_idx == IDX_RAW_FIRST) begin
      hit_raw1 = 1'b1;
    end else if (word_idx == IDX_RAW_SECOND) begin
      hit_raw2 = 1'b1;
    end
  end

  assign mapped = hit_flags | hit_mask | hit_raw1 | hit_raw2;

  // ----------------------------------------------------------------
  // APB handshake
  // ----------------------------------------------------------------

  // The slave never stalls: every access phase completes at once.
  assign pready = 1'b1;
  assign setup_phase = psel & ~penable;
  assign wr_en = psel & penable & pwrite;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  // Read data mux; unmapped addresses read zero.
  always_comb begin
    rdata_d = '0;
    if (hit_flags) begin
      rdata_d[ALARM_CHANNELS-1:0] = fb.flags;
    end else if (hit_mask) begin
      rdata_d[REG_W-1:0] = mask_q[mask_sel];
    end else if (hit_raw1) begin
      rdata_d[REG_W-1:0] = raw_first_q;
    end else if (hit_raw2) begin
      rdata_d[REG_W-1:0] = raw_second_q;
    end
  end

  // Read data and error are captured in the setup cycle, so they come
  // from flip-flops and stand through the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end else if (setup_phase) begin
      prdata_q <= pwrite ? '0 : rdata_d;
      pslverr_q <= ~mapped;
    end
  end

  // ----------------------------------------------------------------
  // Alarm flags
  // ----------------------------------------------------------------

  // Write-one-to-clear pulse toward the flag bank; zeros leave flags alone.
  assign fb.events = alarm_event;
  assign fb.clear = (wr_en && hit_flags) ? pwdata[ALARM_CHANNELS-1:0] : '0;

  // ----------------------------------------------------------------
  // Mask bank
  // ----------------------------------------------------------------

  // One mask word per flag register; the last word gates the alarm flags.
  for (genvar i = 0; i < MASK_COUNT; i++) begin : g_mask
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mask_q[i] <= MASK_RESET;
      end else if (wr_en && hit_mask && mask_sel == MASK_SEL_W'(i)) begin
        mask_q[i] <= pwdata[REG_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------

  // A set mask bit blocks its flag; any unblocked flag raises the line.
  assign alarm_mask = mask_q[ALARM_MASK_ENTRY][ALARM_CHANNELS-1:0];
  assign pending = fb.flags & ~alarm_mask;
  assign irq_out = irq_q;

  // Registered level interrupt.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |pending;
    end
  end

  // ----------------------------------------------------------------
  // Raw status
  // ----------------------------------------------------------------

  // First raw status word: host port error and boot progress.
  always_comb begin
    raw_first_d = RAW_RESET;
    raw_first_d[POS_HOST_ERR] = host_port_error_state;
    raw_first_d[POS_BOOT_DONE] = boot_done;
  end

  // Second raw status word: clock shortfalls and loop states.
  always_comb begin
    raw_second_d = RAW_RESET;
    raw_second_d[POS_CORE_CLK] = core_clock_shortfall_state;
    raw_second_d[POS_ASYNC_CLK] = async_clock_shortfall_state;
    raw_second_d[POS_MAIN_CLK] = system_clock_shortfall_state;
    raw_second_d[POS_B_LOCK] = loop_b_lock_state;
    raw_second_d[POS_B_REF] = loop_b_ref_loss_state;
    raw_second_d[POS_A_LOCK] = loop_a_lock_state;
    raw_second_d[POS_A_REF] = loop_a_ref_loss_state;
  end

  // Raw words follow their sources every cycle; bus writes never reach them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_first_q <= RAW_RESET;
      raw_second_q <= RAW_RESET;
    end else begin
      raw_first_q <= raw_first_d;
      raw_second_q <= raw_second_d;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_irq_follows_pending: assert property (
    ##1 irq_out == $past(|(fb.flags & ~alarm_mask)))
    else $error("interrupt output does not match unmasked flags");

  a_mask_blocks_irq: assert property (
    (alarm_mask == '1) |=> !irq_out)
    else $error("fully masked flags still raised the interrupt");

  a_mask_write_stored: assert property (
    (wr_en && hit_mask) |=> mask_q[$past(mask_sel)] == $past(pwdata[REG_W-1:0]))
    else $error("mask write was not stored");

  a_host_err_live: assert property (
    ##1 raw_first_q[POS_HOST_ERR] == $past(host_port_error_state))
    else $error("host port error bit does not track its source");

  a_boot_bit_live: assert property (
    ##1 raw_first_q[POS_BOOT_DONE] == $past(boot_done))
    else $error("boot bit does not track boot progress");

  a_clock_shortfall: assert property (
    ##1 {raw_second_q[POS_CORE_CLK], raw_second_q[POS_ASYNC_CLK], raw_second_q[POS_MAIN_CLK]}
      == $past({core_clock_shortfall_state, async_clock_shortfall_state,
                system_clock_shortfall_state}))
    else $error("clock shortfall bits do not track their sources");

  a_loop_states: assert property (
    ##1 {raw_second_q[POS_B_LOCK], raw_second_q[POS_B_REF],
         raw_second_q[POS_A_LOCK], raw_second_q[POS_A_REF]}
      == $past({loop_b_lock_state, loop_b_ref_loss_state,
                loop_a_lock_state, loop_a_ref_loss_state}))
    else $error("loop lock or reference bits do not track their sources");

  a_raw_write_ignored: assert property (
    (wr_en && (hit_raw1 || hit_raw2)) |=> raw_first_q == $past(raw_first_d)
      && raw_second_q == $past(raw_second_d))
    else $error("write disturbed a raw status register");

  // ----------------------------------------------------------------
  // Register path checks
  // ----------------------------------------------------------------

  // A flag register read returns the flags as they stood at the setup edge.
  a_flag_read_path: assert property (
    (setup_phase && !pwrite && hit_flags)
      |=> prdata == DATA_W'($past(fb.flags)))
    else $error("flag register read returned the wrong value");

  // Zeros written to the flag register must leave every set flag set.
  // This guards the clear path from the bus as well as the bank itself.
  a_zero_write_keeps: assert property (
    (wr_en && hit_flags && pwdata[ALARM_CHANNELS-1:0] == '0)
      |=> (fb.flags & $past(fb.flags)) == $past(fb.flags))
    else $error("writing zero to the flag register cleared a flag");

  // A read of the first raw word returns the word held at the setup edge.
  a_raw_first_read: assert property (
    (setup_phase && !pwrite && hit_raw1)
      |=> prdata == DATA_W'($past(raw_first_q)))
    else $error("first raw status read returned the wrong value");

  // A read of the second raw word returns the word held at the setup edge.
  a_raw_second_read: assert property (
    (setup_phase && !pwrite && hit_raw2)
      |=> prdata == DATA_W'($past(raw_second_q)))
    else $error("second raw status read returned the wrong value");

  // The alarm mask word changes only when the bus writes that very word.
  // A decode slip here would silently unmask or mask a channel.
  a_alarm_mask_held: assert property (
    !(wr_en && hit_mask && mask_sel == ALARM_MASK_ENTRY)
      |=> $stable(alarm_mask))
    else $error("alarm mask changed without a write to its word");

  // A mask read returns the whole stored word.
  a_mask_read_path: assert property (
    (setup_phase && !pwrite && hit_mask)
      |=> prdata == DATA_W'($past(mask_q[mask_sel])))
    else $error("mask read returned the wrong value");

  // An unmasked set flag must raise the line one cycle later.
  a_unmasked_raises: assert property (
    ((fb.flags & ~alarm_mask) != '0)
      |=> irq_out)
    else $error("unmasked flag did not raise the interrupt");

  // With no flag set the line must be low one cycle later.
  // Stale interrupt state after a clear would show up here.
  a_no_flag_quiet: assert property (
    (fb.flags == '0)
      |=> !irq_out)
    else $error("interrupt raised with no flag set");

  // Main scenarios worth seeing in a run.
  c_masked_flag_held: cover property (fb.flags != '0 && alarm_mask == '1);
  c_irq_raised: cover property ($rose(irq_out));
  c_flag_cleared: cover property (wr_en && hit_flags && fb.flags != '0);
  c_unmapped_error: cover property (psel && penable && pslverr);

endmodule : irq_ctrl_top

// ===== verilog/irq_pkg.sv
/*
  Shared constants for the interrupt flag, mask and raw status block.
  Assumes a 32-bit APB register bus clocked at 200 MHz.
*/
package irq_pkg;

  // ----------------------------------------------------------------
  // Bus widths and register indices (byte address is four times these)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam int IDX_W = 14;
  localparam logic [IDX_W-1:0] IDX_ALARM_FLAGS = 14'h1823;
  localparam logic [IDX_W-1:0] IDX_MASK_FIRST = 14'h1840;
  localparam logic [IDX_W-1:0] IDX_MASK_LAST = 14'h1863;
  localparam logic [IDX_W-1:0] IDX_RAW_FIRST = 14'h1880;
  localparam logic [IDX_W-1:0] IDX_RAW_SECOND = 14'h1881;

  // ----------------------------------------------------------------
  // Mask bank layout
  // ----------------------------------------------------------------
  localparam int MASK_COUNT = 36;
  localparam int MASK_SEL_W = 6;
  localparam logic [MASK_SEL_W-1:0] ALARM_MASK_ENTRY =
    MASK_SEL_W'(IDX_MASK_LAST - IDX_MASK_FIRST);

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ALARM_CHANNELS = 4;
  localparam int POS_HOST_ERR = 12;
  localparam int POS_BOOT_DONE = 7;
  localparam int POS_CORE_CLK = 14;
  localparam int POS_ASYNC_CLK = 13;
  localparam int POS_MAIN_CLK = 12;
  localparam int POS_B_LOCK = 9;
  localparam int POS_A_LOCK = 8;
  localparam int POS_B_REF = 6;
  localparam int POS_A_REF = 5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [REG_W-1:0] FLAGS_RESET = 16'h0000;
  localparam logic [REG_W-1:0] MASK_RESET = 16'hffff;
  localparam logic [REG_W-1:0] RAW_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int BOOT_TIME_NS = 2000;
  localparam int BOOT_CYCLES = (BOOT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int BOOT_CNT_W = 9;

  // Boot sequencer states.
  typedef enum logic {BOOT_RUN, BOOT_IDLE} boot_state_type;

endpackage : irq_pkg

// ===== verilog/flag_bus_if.sv
/*
  Carrier between the register front end and the alarm flag bank.
  Assumes both ends share pclk.
*/
`timescale 1ns/1ps
interface flag_bus_if;
  logic [irq_pkg::ALARM_CHANNELS-1:0] events;
  logic [irq_pkg::ALARM_CHANNELS-1:0] clear;
  logic [irq_pkg::ALARM_CHANNELS-1:0] flags;
  modport bank (input events, input clear, output flags);
  modport ctrl (output events, output clear, input flags);
endinterface : flag_bus_if

// ===== verilog/alarm_flag_bank.sv
/*
  Latched alarm channel flags: rising edge sets, write-one clears.
  Assumes events and clear pulses are synchronous to pclk.
*/
`timescale 1ns/1ps
module alarm_flag_bank (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Flag carrier.
  flag_bus_if.bank fb
);
  import irq_pkg::*;

  logic [ALARM_CHANNELS-1:0] prev_q;
  logic [ALARM_CHANNELS-1:0] flags_q;
  logic [ALARM_CHANNELS-1:0] rise;

  // A new edge beats a clear in the same cycle, so no event is lost.
  assign rise = fb.events & ~prev_q;
  assign fb.flags = flags_q;

  // Previous event level for edge detection.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= '0;
    end else begin
      prev_q <= fb.events;
    end
  end

  // Sticky flags.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= FLAGS_RESET[ALARM_CHANNELS-1:0];
    end else begin
      flags_q <= (flags_q & ~fb.clear) | rise;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_edge_sets_flag: assert property (|rise |=> (flags_q & $past(rise)) == $past(rise))
    else $error("rising alarm event did not set its flag");
  a_one_clears_flag: assert property (
    (fb.clear != '0 && (fb.clear & rise) == '0) |=> (flags_q & $past(fb.clear)) == '0)
    else $error("write of one did not clear the flag");
  a_zero_keeps_flag: assert property (
    (fb.clear == '0 && rise == '0) |=> flags_q == $past(flags_q))
    else $error("flag changed without edge or clear");

endmodule : alarm_flag_bank

// ===== verilog/boot_sequencer.sv
/*
  Boot sequencer: busy for a fixed time after reset, then idle.
  Assumes presetn starts the sequence.
*/
`timescale 1ns/1ps
module boot_sequencer (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Boot status.
  output logic boot_done
);
  import irq_pkg::*;

  boot_state_type state_q;
  logic [BOOT_CNT_W-1:0] cnt_q;

  assign boot_done = (state_q == BOOT_IDLE);

  // Count the boot time, then stay idle until the next reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= BOOT_RUN;
      cnt_q <= '0;
    end else begin
      case (state_q)
        BOOT_RUN: begin
          if (cnt_q == BOOT_CNT_W'(BOOT_CYCLES - 1)) begin
            state_q <= BOOT_IDLE;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        default: begin
          state_q <= BOOT_IDLE;
        end
      endcase
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_boot_ends_on_count: assert property (
    (state_q == BOOT_RUN && cnt_q != BOOT_CNT_W'(BOOT_CYCLES - 1)) |=> !boot_done)
    else $error("boot reported done before the boot time elapsed");
  c_boot_finishes: cover property ($rose(boot_done));

endmodule : boot_sequencer

// ===== sim/irq_status_mask_raw_bank_tb_top.sv
/*
  Self-checking bench for the interrupt flag, mask and raw status block.
  Assumes irq_pkg and irq_ctrl_top are compiled first; assertions live in the design.
*/
`timescale 1ns/1ps
module irq_status_mask_raw_bank_tb_top;
  import irq_pkg::*;

  // ----------------------------------------------------------------
  // Signals and bookkeeping
  // ----------------------------------------------------------------
  typedef struct {logic [31:0] data; logic err; logic is_read;} exp_note_type;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic pready;
  logic [DATA_W-1:0] prdata;
  logic pslverr;
  logic [ALARM_CHANNELS-1:0] alarm_event = '0;
  logic [7:0] live = '0;
  logic irq_out;
  exp_note_type exp_q[$];
  exp_note_type cur;
  int fail_count = 0;
  int comparisons = 0;
  logic [31:0] rnd;
  logic [3:0] exp_flags;
  logic [15:0] exp1;
  logic [15:0] exp2;

  irq_ctrl_top irq_ctrl_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .alarm_event(alarm_event), .host_port_error_state(live[0]),
    .core_clock_shortfall_state(live[1]), .async_clock_shortfall_state(live[2]),
    .system_clock_shortfall_state(live[3]), .loop_a_lock_state(live[4]),
    .loop_b_lock_state(live[5]), .loop_a_ref_loss_state(live[6]),
    .loop_b_ref_loss_state(live[7]), .irq_out(irq_out)
  );

  // Clock at 200 MHz.
  always #2.5 pclk = ~pclk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict

  // Byte address of a register index.
  function automatic logic [15:0] ba(input logic [IDX_W-1:0] idx);
    return {idx, 2'b00};
  endfunction : ba

  // One APB transfer; psel stays high so a following call runs back to back.
  task automatic apb(input logic wr, input logic [15:0] addr, input logic [31:0] wd,
                     input logic [31:0] ed, input logic ee);
    int n;
    exp_note_type note;
    note.data = ed;
    note.err = ee;
    note.is_read = !wr;
    exp_q.push_back(note);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fail_count++;
      give_verdict();
    end
  endtask : apb

  // Releases the bus and lets the given number of edges pass.
  task automatic idle(input int n);
    psel <= 1'b0;
    repeat (n) @(posedge pclk);
  endtask : idle

  // ----------------------------------------------------------------
  // Result watcher: takes the oldest note at each completed transfer
  // ----------------------------------------------------------------
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(32'h1, 32'h0);
      end else begin
        cur = exp_q.pop_front();
        if (cur.is_read) begin
          check(prdata, cur.data);
        end
        check({31'h0, pslverr}, {31'h0, cur.err});
      end
    end
  end

  // Watchdog against a hang.
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rnd = $urandom(32'hdcb39ce9);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, boot still running.
    apb(1'b0, ba(IDX_RAW_FIRST), '0, 32'h0, 1'b0);
    apb(1'b0, ba(IDX_RAW_SECOND), '0, 32'h0, 1'b0);
    apb(1'b0, ba(IDX_ALARM_FLAGS), '0, 32'h0, 1'b0);
    apb(1'b0, ba(IDX_MASK_LAST), '0, {16'h0, MASK_RESET}, 1'b0);
    idle(1);
    check({31'h0, irq_out}, 32'h0);
    // Host waits for boot completion before writing.
    idle(BOOT_CYCLES);
    apb(1'b0, ba(IDX_RAW_FIRST), '0, 32'h80, 1'b0);
    // Live status bits follow random conditions; writes leave them alone.
    for (int i = 0; i < 8; i++) begin
      rnd = $urandom;
      live <= rnd[7:0];
      idle(3);
      exp1 = 16'h0080 | (16'(rnd[0]) << POS_HOST_ERR);
      exp2 = (16'(rnd[1]) << POS_CORE_CLK) | (16'(rnd[2]) << POS_ASYNC_CLK)
           | (16'(rnd[3]) << POS_MAIN_CLK) | (16'(rnd[4]) << POS_A_LOCK)
           | (16'(rnd[5]) << POS_B_LOCK) | (16'(rnd[6]) << POS_A_REF)
           | (16'(rnd[7]) << POS_B_REF);
      apb(1'b0, ba(IDX_RAW_FIRST), '0, {16'h0, exp1}, 1'b0);
      apb(1'b0, ba(IDX_RAW_SECOND), '0, {16'h0, exp2}, 1'b0);
      apb(1'b1, ba(IDX_RAW_SECOND), ~{16'h0, exp2}, 32'h0, 1'b0);
      apb(1'b1, ba(IDX_RAW_FIRST), 32'hffff_ffff, 32'h0, 1'b0);
      apb(1'b0, ba(IDX_RAW_SECOND), '0, {16'h0, exp2}, 1'b0);
      apb(1'b0, ba(IDX_RAW_FIRST), '0, {16'h0, exp1}, 1'b0);
    end
    // Every mask word holds what was written.
    for (int i = 0; i < MASK_COUNT; i++) begin
      rnd = $urandom;
      apb(1'b1, ba(IDX_MASK_FIRST + IDX_W'(i)), rnd, 32'h0, 1'b0);
      apb(1'b0, ba(IDX_MASK_FIRST + IDX_W'(i)), '0, {16'h0, rnd[15:0]}, 1'b0);
    end
    // Unmapped places answer with an error and read zero; a misaligned write answers with an error.
    apb(1'b0, 16'h0000, '0, 32'h0, 1'b1);
    apb(1'b1, ba(IDX_ALARM_FLAGS) + 16'h1, 32'hf, 32'h0, 1'b1);
    apb(1'b0, ba(IDX_MASK_LAST + 14'h1), '0, 32'h0, 1'b1);
    apb(1'b1, ba(IDX_MASK_LAST), 32'h0000_000f, 32'h0, 1'b0);
    idle(1);
    // Random rising edges set flags; masked flags keep the output low.
    rnd = $urandom;
    alarm_event <= rnd[3:0] | 4'h1;
    exp_flags = rnd[3:0] | 4'h1;
    idle(3);
    apb(1'b0, ba(IDX_ALARM_FLAGS), '0, {28'h0, exp_flags}, 1'b0);
    apb(1'b1, ba(IDX_ALARM_FLAGS), 32'hffff_fff0, 32'h0, 1'b0);
    apb(1'b0, ba(IDX_ALARM_FLAGS), '0, {28'h0, exp_flags}, 1'b0);
    idle(3);
    check({31'h0, irq_out}, 32'h0);
    alarm_event <= 4'h0;
    idle(2);
    alarm_event <= 4'hf;
    exp_flags = 4'hf;
    idle(3);
    apb(1'b0, ba(IDX_ALARM_FLAGS), '0, 32'hf, 1'b0);
    // Unmask one channel at a time, then clear it while its level stays high.
    for (int ch = 0; ch < ALARM_CHANNELS; ch++) begin
      apb(1'b1, ba(IDX_MASK_LAST), {16'h0, ~(16'h1 << ch)}, 32'h0, 1'b0);
      idle(3);
      check({31'h0, irq_out}, 32'h1);
      apb(1'b1, ba(IDX_ALARM_FLAGS), 32'h1 << ch, 32'h0, 1'b0);
      exp_flags[ch] = 1'b0;
      idle(3);
      check({31'h0, irq_out}, 32'h0);
      apb(1'b0, ba(IDX_ALARM_FLAGS), '0, {28'h0, exp_flags}, 1'b0);
    end
    // All unmasked with no flag left: output stays low.
    apb(1'b1, ba(IDX_MASK_LAST), 32'h0, 32'h0, 1'b0);
    idle(4);
    check({31'h0, irq_out}, 32'h0);
    give_verdict();
  end
endmodule : irq_status_mask_raw_bank_tb_top
